// [acms_regs.vh]
/*
  register indices, field positions, reset values and codes of the
  access-channel and operating-mode selector.
  assumes inclusion by acms_top.v and its leaf modules only.
*/
`ifndef ACMS_REGS_VH
`define ACMS_REGS_VH

// ----------------------------------------------------------------------------
// parameter addresses: index and subindex
// ----------------------------------------------------------------------------
`define ACMS_IDX_IO_ASSIGN        16'h001D
`define ACMS_SUB_IO_ASSIGN        8'h1F
`define ACMS_IDX_ABS_TARGET       16'h0023
`define ACMS_SUB_ABS_TARGET       8'h01
`define ACMS_IDX_CHANNEL_LOCK     16'h001D
`define ACMS_SUB_CHANNEL_LOCK     8'h1E
`define ACMS_IDX_ACTIVE_MODE      16'h001C
`define ACMS_SUB_ACTIVE_MODE      8'h03

// ----------------------------------------------------------------------------
// access codes and reset values
// ----------------------------------------------------------------------------
`define ACMS_ACC_WRITE            8'h04
`define ACMS_ACC_READ             8'h03
`define ACMS_RST_IO_ASSIGN        16'h0000
`define ACMS_RST_ABS_TARGET       32'h0000_0000
`define ACMS_RST_CHANNEL_LOCK     16'h0000

// ----------------------------------------------------------------------------
// i/o assignment setting values
// ----------------------------------------------------------------------------
`define ACMS_IO_FIELDBUS_CFG      16'h0000
`define ACMS_IO_FREE              16'h0001
`define ACMS_IO_FIXED             16'h0002

// ----------------------------------------------------------------------------
// active mode codes (5 bits) and field positions of the acknowledgement
// ----------------------------------------------------------------------------
`define ACMS_MODE_NONE            5'h00
`define ACMS_MODE_MANUAL          5'h01
`define ACMS_MODE_PTP             5'h03
`define ACMS_MODE_SPEED           5'h04
`define ACMS_MODE_GEAR            5'h05
`define ACMS_MODE_HOMING          5'h06
`define ACMS_MODE_SETUP           5'h07
`define ACMS_ACK_HOMED_BIT        5
`define ACMS_ACK_DONE_BIT         1
`define ACMS_ACK_AMP_BIT          2

// ----------------------------------------------------------------------------
// channel codes
// ----------------------------------------------------------------------------
`define ACMS_CH_NONE              2'h0
`define ACMS_CH_LOCAL             2'h1
`define ACMS_CH_SIGIO             2'h2
`define ACMS_CH_FIELDBUS          2'h3

`endif

// [acms_sync.v]
/*
  two-flop level synchroniser for the remote-select input.
  assumes a level input that may change at any time.
*/
`timescale 1ns/1ns
`default_nettype none

module acms_sync
(
  input  wire clk_i,   // system clock
  input  wire rst_i,   // synchronous reset, high
  input  wire d_i,     // asynchronous level
  output reg  q_o      // synchronised level
);

  reg meta;

  // ---------------------------------------------------------------------------
  // first flop feeds only the second, so one change is seen exactly once
  // ---------------------------------------------------------------------------
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta <= 1'b0;
      q_o  <= 1'b0;
    end
    else
    begin
      meta <= d_i;
      q_o  <= meta;
    end
  end

endmodule // acms_sync
`default_nettype wire

// [acms_done.v]
/*
  motion-done flag: cleared on start, set on finish unless a start
  comes in the same cycle.
  assumes start and finish are one-cycle pulses.
*/
`timescale 1ns/1ns
`default_nettype none

module acms_done
(
  input  wire clk_i,          // system clock
  input  wire rst_i,          // synchronous reset, high
  input  wire start_i,        // operation start pulse
  input  wire finish_i,       // operation finish pulse
  output reg  done_o          // motion done flag
);

  // ---------------------------------------------------------------------------
  // a start wins over a finish, which suppresses the set on back-to-back ops
  // ---------------------------------------------------------------------------
  always @(posedge clk_i)
  begin
    if (rst_i)
      done_o <= 1'b1;
    else if (start_i)
      done_o <= 1'b0;
    else if (finish_i)
      done_o <= 1'b1;
  end

endmodule // acms_done
`default_nettype wire

// [acms_top.v]
/*
  access-channel arbiter and operating-mode selector of a servo positioning
  controller, with fieldbus parameter access and acknowledgement.
  assumes all inputs synchronous to SYS_CLK_I except REMOTE_SELECT_I, and a
  motion core that reports completion with MOTION_FINISH_I.
*/
`timescale 1ns/1ns
`default_nettype none
`include "acms_regs.vh"

module acms_top
(
  input  wire        SYS_CLK_I,         // 125 MHz system clock
  input  wire        SRST_I,            // synchronous reset, high
  input  wire        REMOTE_SELECT_I,   // low local, high fieldbus
  // fieldbus command strobe with its fields
  input  wire        FB_CMD_VALID_I,    // one-cycle command strobe
  input  wire [7:0]  FB_ACCESS_I,       // access code byte
  input  wire [7:0]  FB_SUBINDEX_I,     // subindex byte
  input  wire [15:0] FB_INDEX_I,        // index word
  input  wire [31:0] FB_DATA_I,         // data word
  input  wire [4:0]  FB_MODE_I,         // mode of a fieldbus movement command
  input  wire        FB_MOVE_I,         // fieldbus movement command strobe
  input  wire        FB_STOP_I,         // fieldbus stop strobe
  // local hand-held unit / commissioning tool
  input  wire        LOC_MOVE_I,        // local movement command strobe
  input  wire [4:0]  LOC_MODE_I,        // requested mode
  input  wire        LOC_STOP_I,        // local stop strobe
  input  wire        LOC_WR_I,          // local parameter write strobe
  input  wire [15:0] LOC_INDEX_I,       // local write index
  input  wire [7:0]  LOC_SUBINDEX_I,    // local write subindex
  input  wire [31:0] LOC_DATA_I,        // local write data
  // discrete signal interface
  input  wire        SIG_MANUAL_I,      // manual-mode request strobe
  input  wire        SIG_STOP_I,        // stop strobe
  // motion core
  input  wire        MOTION_FINISH_I,   // operation finished pulse
  input  wire        HOMED_I,           // axis referenced
  input  wire        AMP_ON_I,          // amplifier enabled
  // outputs
  output reg         REMOTE_SELECT_ACK_O, // switched source, high fieldbus
  output reg         PIN_FB_CFG_O,      // pins carry fieldbus configuration
  output reg         PIN_FREE_IO_O,     // pins free user i/o
  output reg         PIN_FIXED_O,       // pins predefined functions
  output reg         START_O,           // operation start pulse
  output reg  [4:0]  START_MODE_O,      // mode being started
  output reg  [31:0] TARGET_O,          // absolute target for the core
  output reg         STOP_O,            // stop pulse to the core
  output reg  [4:0]  ACTIVE_MODE_O,     // active mode status
  output reg  [1:0]  OWNER_O,           // channel owning mode control
  output reg         MOTION_DONE_O,     // motion done flag
  output reg         REJECT_O,          // command refused pulse
  output reg         FB_ACK_VALID_O,    // acknowledgement strobe
  output reg  [31:0] FB_ACK_STATUS_O,   // acknowledgement status word
  output reg  [31:0] FB_ACK_DATA_O      // acknowledgement data word
);

  reg  [15:0] io_assignment_setting;
  reg  [31:0] absolute_target_position;
  reg  [15:0] channel_lock;
  reg         remote_select_ack;
  reg         busy;
  reg  [1:0]  owner;
  reg  [4:0]  active_mode_code;
  wire        remote_select;
  wire        done_flag;

  reg         next_start;
  reg  [4:0]  next_mode;
  reg  [1:0]  next_chan;
  reg         next_reject;
  reg         next_tgt_load;
  reg  [31:0] next_tgt;

  // ---------------------------------------------------------------------------
  // remote-select synchroniser and motion-done flag
  // ---------------------------------------------------------------------------
  acms_sync u_sync
  (
    .clk_i (SYS_CLK_I),
    .rst_i (SRST_I),
    .d_i   (REMOTE_SELECT_I),
    .q_o   (remote_select)
  );

  acms_done u_done
  (
    .clk_i    (SYS_CLK_I),
    .rst_i    (SRST_I),
    .start_i  (next_start),
    .finish_i (MOTION_FINISH_I),
    .done_o   (done_flag)
  );

  // ---------------------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------------------
  wire fixed     = (io_assignment_setting == `ACMS_IO_FIXED);
  wire fb_write  = FB_CMD_VALID_I && (FB_ACCESS_I == `ACMS_ACC_WRITE);
  wire fb_target = fb_write && (FB_INDEX_I == `ACMS_IDX_ABS_TARGET)
                   && (FB_SUBINDEX_I == `ACMS_SUB_ABS_TARGET);
  wire fb_lock   = fb_write && (FB_INDEX_I == `ACMS_IDX_CHANNEL_LOCK)
                   && (FB_SUBINDEX_I == `ACMS_SUB_CHANNEL_LOCK);
  wire loc_set   = LOC_WR_I && (LOC_INDEX_I == `ACMS_IDX_IO_ASSIGN)
                   && (LOC_SUBINDEX_I == `ACMS_SUB_IO_ASSIGN);
  wire loc_tgt   = LOC_WR_I && (LOC_INDEX_I == `ACMS_IDX_ABS_TARGET)
                   && (LOC_SUBINDEX_I == `ACMS_SUB_ABS_TARGET);
  // local tools usable unless fixed+remote, or not fixed and the fieldbus locked them out
  wire loc_ok    = fixed ? !remote_select_ack : (channel_lock[0] == 1'b0);
  wire fb_ok     = fixed ? remote_select_ack : 1'b1;
  // signal-io only in fixed local mode, and then only manual
  wire sig_ok    = fixed && !remote_select_ack;

  // ---------------------------------------------------------------------------
  // mode-start arbitration; fieldbus wins, then local, then signal-io when several arrive together
  // ---------------------------------------------------------------------------
  always @*
  begin
    next_start    = 1'b0;
    next_mode     = `ACMS_MODE_NONE;
    next_chan     = `ACMS_CH_NONE;
    next_reject   = 1'b0;
    next_tgt_load = 1'b0;
    next_tgt      = absolute_target_position;
    if (fb_target || (FB_MOVE_I && FB_MODE_I != `ACMS_MODE_SETUP))
    begin
      if (fb_ok && (!busy || owner == `ACMS_CH_FIELDBUS))
      begin
        next_start = 1'b1;
        next_chan  = `ACMS_CH_FIELDBUS;
        next_mode  = fb_target ? `ACMS_MODE_PTP : FB_MODE_I;
        if (fb_target)
        begin
          next_tgt_load = 1'b1;
          next_tgt      = FB_DATA_I;
        end
      end
      else
        next_reject = 1'b1;
    end
    else if (FB_MOVE_I)
      next_reject = 1'b1;                  // setup never over the fieldbus
    else if (LOC_MOVE_I || loc_tgt)
    begin
      if (loc_ok && (!busy || owner == `ACMS_CH_LOCAL))
      begin
        next_start = 1'b1;
        next_chan  = `ACMS_CH_LOCAL;
        next_mode  = loc_tgt ? `ACMS_MODE_PTP : LOC_MODE_I;
        if (loc_tgt)
        begin
          next_tgt_load = 1'b1;
          next_tgt      = LOC_DATA_I;
        end
      end
      else
        next_reject = 1'b1;
    end
    else if (SIG_MANUAL_I)
    begin
      if (sig_ok && (!busy || owner == `ACMS_CH_SIGIO))
      begin
        next_start = 1'b1;
        next_chan  = `ACMS_CH_SIGIO;
        next_mode  = `ACMS_MODE_MANUAL;
      end
      else
        next_reject = 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // parameter store; the setting is only writable locally, never by fieldbus
  // ---------------------------------------------------------------------------
  always @(posedge SYS_CLK_I)
  begin
    if (SRST_I)
    begin
      io_assignment_setting    <= `ACMS_RST_IO_ASSIGN;
      absolute_target_position <= `ACMS_RST_ABS_TARGET;
      channel_lock             <= `ACMS_RST_CHANNEL_LOCK;
    end
    else
    begin
      if (loc_set && !busy)
        io_assignment_setting <= LOC_DATA_I[15:0];
      if (next_tgt_load)
        absolute_target_position <= next_tgt;
      if (fb_lock)
        channel_lock <= FB_DATA_I[15:0];
    end
  end

  // ---------------------------------------------------------------------------
  // operation ownership and deferred source switch
  // ---------------------------------------------------------------------------
  always @(posedge SYS_CLK_I)
  begin
    if (SRST_I)
    begin
      busy              <= 1'b0;
      owner             <= `ACMS_CH_NONE;
      active_mode_code  <= `ACMS_MODE_NONE;
      remote_select_ack <= 1'b0;
    end
    else
    begin
      if (next_start)
      begin
        busy             <= 1'b1;
        owner            <= next_chan;
        active_mode_code <= next_mode;
      end
      else if (MOTION_FINISH_I)
      begin
        busy  <= 1'b0;
        owner <= `ACMS_CH_NONE;
      end
      // switching mid-move would hand a running axis to a new master
      if (!busy && !next_start)
        remote_select_ack <= remote_select;
    end
  end

  // ---------------------------------------------------------------------------
  // registered outputs and fieldbus acknowledgement
  // ---------------------------------------------------------------------------
  always @(posedge SYS_CLK_I)
  begin
    if (SRST_I)
    begin
      REMOTE_SELECT_ACK_O <= 1'b0;
      PIN_FB_CFG_O        <= 1'b1;
      PIN_FREE_IO_O       <= 1'b0;
      PIN_FIXED_O         <= 1'b0;
      START_O             <= 1'b0;
      START_MODE_O        <= `ACMS_MODE_NONE;
      TARGET_O            <= `ACMS_RST_ABS_TARGET;
      STOP_O              <= 1'b0;
      ACTIVE_MODE_O       <= `ACMS_MODE_NONE;
      OWNER_O             <= `ACMS_CH_NONE;
      MOTION_DONE_O       <= 1'b1;
      REJECT_O            <= 1'b0;
      FB_ACK_VALID_O      <= 1'b0;
      FB_ACK_STATUS_O     <= 32'h0000_0000;
      FB_ACK_DATA_O       <= 32'h0000_0000;
    end
    else
    begin
      REMOTE_SELECT_ACK_O <= remote_select_ack;
      PIN_FB_CFG_O        <= (io_assignment_setting == `ACMS_IO_FIELDBUS_CFG);
      PIN_FREE_IO_O       <= (io_assignment_setting == `ACMS_IO_FREE);
      PIN_FIXED_O         <= fixed;
      START_O             <= next_start;
      START_MODE_O        <= next_mode;
      TARGET_O            <= next_tgt_load ? next_tgt : absolute_target_position;
      STOP_O              <= FB_STOP_I | LOC_STOP_I | SIG_STOP_I;
      ACTIVE_MODE_O       <= next_start ? next_mode : active_mode_code;
      OWNER_O             <= next_start ? next_chan : owner;
      MOTION_DONE_O       <= done_flag;
      REJECT_O            <= next_reject;
      FB_ACK_VALID_O      <= FB_CMD_VALID_I;
      FB_ACK_STATUS_O     <= 32'h0000_0000;
      FB_ACK_STATUS_O[`ACMS_ACK_HOMED_BIT] <= HOMED_I;
      FB_ACK_STATUS_O[4:0] <= next_start ? next_mode : active_mode_code;
      FB_ACK_STATUS_O[`ACMS_ACK_DONE_BIT + 16] <= done_flag & ~next_start;
      FB_ACK_STATUS_O[`ACMS_ACK_AMP_BIT + 16]  <= AMP_ON_I;
      FB_ACK_DATA_O       <= (FB_ACCESS_I == `ACMS_ACC_READ) ?
                             absolute_target_position : 32'h0000_0000;
    end
  end

endmodule // acms_top
`default_nettype wire

// [acms_chk.sv]
/*
  assertions on the ports of the access-channel and mode selector.
  assumes attachment by bind to acms_top and a single clock domain.
*/
`timescale 1ns/1ns
`default_nettype none

module acms_chk
(
  input wire logic        SYS_CLK_I,           // clock
  input wire logic        SRST_I,              // sync reset
  input wire logic        REMOTE_SELECT_I,     // remote select level
  input wire logic        FB_CMD_VALID_I,      // fieldbus command
  input wire logic [7:0]  FB_ACCESS_I,         // access code
  input wire logic [7:0]  FB_SUBINDEX_I,       // subindex
  input wire logic [15:0] FB_INDEX_I,          // index
  input wire logic [31:0] FB_DATA_I,           // data
  input wire logic [4:0]  FB_MODE_I,           // fieldbus mode
  input wire logic        FB_MOVE_I,           // fieldbus move
  input wire logic        FB_STOP_I,           // fieldbus stop
  input wire logic        LOC_MOVE_I,          // local move
  input wire logic        LOC_STOP_I,          // local stop
  input wire logic        LOC_WR_I,            // local write
  input wire logic        SIG_MANUAL_I,        // pin manual request
  input wire logic        SIG_STOP_I,          // pin stop
  input wire logic        MOTION_FINISH_I,     // core finish
  input wire logic        REMOTE_SELECT_ACK_O, // switched source
  input wire logic        PIN_FB_CFG_O,        // pins fieldbus cfg
  input wire logic        PIN_FREE_IO_O,       // pins free
  input wire logic        PIN_FIXED_O,         // pins fixed
  input wire logic        START_O,             // start pulse
  input wire logic [4:0]  START_MODE_O,        // started mode
  input wire logic [31:0] TARGET_O,            // target
  input wire logic        STOP_O,              // stop pulse
  input wire logic        MOTION_DONE_O,       // done flag
  input wire logic        REJECT_O,            // refusal pulse
  input wire logic        FB_ACK_VALID_O       // acknowledgement
);
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (SRST_I);

  // any stop source; none of them may ever be dropped
  wire logic any_stop = FB_STOP_I | LOC_STOP_I | SIG_STOP_I;

  // --------------------------------------------------------------------------
  // sequences and properties
  // --------------------------------------------------------------------------
  sequence s_ptp_write;
    FB_CMD_VALID_I && FB_ACCESS_I == 8'h04 && FB_INDEX_I == 16'h0023 && FB_SUBINDEX_I == 8'h01;
  endsequence
  // idle, no start in flight, fieldbus not shut out by fixed pins
  sequence s_idle_open;
    MOTION_DONE_O && !START_O && !PIN_FIXED_O && !FB_MOVE_I;
  endsequence
  sequence s_ptp_started;
    START_O && START_MODE_O == 5'h03 && TARGET_O == $past(FB_DATA_I);
  endsequence

  a_ptp_start:
    assert property (s_ptp_write and s_idle_open |=> s_ptp_started)
    else $error("target write did not start absolute move");
  a_stop_always:
    assert property (any_stop |=> STOP_O)
    else $error("stop strobe not passed on");
  a_ack_every:
    assert property (FB_CMD_VALID_I |=> FB_ACK_VALID_O)
    else $error("fieldbus command without acknowledgement");
  a_pins_onehot:
    assert property ($onehot({PIN_FB_CFG_O, PIN_FREE_IO_O, PIN_FIXED_O}))
    else $error("pin function decode not one-hot");
  a_sig_refused:
    assert property (SIG_MANUAL_I && !PIN_FIXED_O && !$past(LOC_WR_I) && !FB_MOVE_I && !LOC_MOVE_I
      && !FB_CMD_VALID_I && !LOC_WR_I |=> REJECT_O && !START_O)
    else $error("pin request accepted without fixed pins");
  a_fb_setup:
    assert property (FB_MOVE_I && FB_MODE_I == 5'h07 && !LOC_MOVE_I && !SIG_MANUAL_I
      && !FB_CMD_VALID_I |=> REJECT_O && !START_O)
    else $error("fieldbus setup mode not refused");
  a_done_clear:
    assert property (START_O |=> !MOTION_DONE_O)
    else $error("done flag not cleared on start");
  a_done_set:
    assert property ($rose(MOTION_DONE_O) |-> $past(MOTION_FINISH_I) || $past(MOTION_FINISH_I, 2))
    else $error("done flag set without finish");
  a_ack_switch:
    assert property ($changed(REMOTE_SELECT_ACK_O) |-> REMOTE_SELECT_ACK_O == $past(REMOTE_SELECT_I, 4))
    else $error("acknowledge disagrees with remote select");
endmodule // acms_chk

`default_nettype wire

// [acms_core_model.sv]
/*
  motion core stand-in: answers a start or stop with a finish pulse; another one while busy reloads the count.
  assumes START_O and STOP_O of the selector are one-cycle pulses.
*/
`timescale 1ns/1ns
`default_nettype none

module acms_core_model
(
  input  wire logic       clk_i,    // system clock
  input  wire logic       rst_i,    // synchronous reset, high
  input  wire logic       start_i,  // operation start pulse
  input  wire logic       stop_i,   // stop pulse
  input  wire logic [7:0] delay_i,  // cycles until finish
  input  wire logic       hold_i,   // stall the finish
  output var  logic       finish_o  // operation finished pulse
);
  logic       busy;
  logic [7:0] cnt;

  // --------------------------------------------------------------------------
  // operation timer
  // --------------------------------------------------------------------------
  // falling edge, so the pulse is settled well before the selector samples it
  always @(negedge clk_i)
  begin
    finish_o <= 1'b0;
    if (rst_i)
      busy <= 1'b0;
    else if (start_i || stop_i)
    begin
      busy <= 1'b1;
      cnt  <= delay_i;
    end
    else if (busy && !hold_i)
    begin
      if (cnt == 8'h00)
      begin
        finish_o <= 1'b1;
        busy     <= 1'b0;
      end
      else
        cnt <= cnt - 8'h01;
    end
  end
endmodule // acms_core_model

`default_nettype wire

// [testbench.sv]
/*
  self-checking bench of the access-channel and mode selector.
  assumes acms_top, acms_core_model and acms_chk are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none

module testbench;
  logic        clk   = 1'b0;
  logic        srst  = 1'b1;
  logic        rsel  = 1'b0;
  logic        fbv   = 1'b0;
  logic        lwr   = 1'b0;
  logic        homed = 1'b1;
  logic        amp   = 1'b1;
  logic        hold  = 1'b0;
  logic [5:0]  strb  = 6'h00; // fb move, loc move, pin manual, fb/loc/pin stop
  logic [4:0]  mode  = 5'h00;
  logic [7:0]  acc   = 8'h00;
  logic [7:0]  sub   = 8'h00;
  logic [7:0]  dly   = 8'h04;
  logic [15:0] idx   = 16'h0000;
  logic [31:0] dat   = 32'h0000_0000;
  logic        ack, pfb, pfree, pfix, st, stp, dn, rej, akv, fin;
  logic [4:0]  stm, am;
  logic [1:0]  own;
  logic [31:0] tgt, aks, akd;
  logic [4:0]  fbm [5] = '{5'h01, 5'h03, 5'h04, 5'h05, 5'h06};
  int          n_fail = 0;
  int          checks_done = 0;
  int          cyc = 0;

  always #4 clk = ~clk;

  acms_top i_dut
  (
    .SYS_CLK_I(clk), .SRST_I(srst), .REMOTE_SELECT_I(rsel), .FB_CMD_VALID_I(fbv),
    .FB_ACCESS_I(acc), .FB_SUBINDEX_I(sub), .FB_INDEX_I(idx), .FB_DATA_I(dat),
    .FB_MODE_I(mode), .FB_MOVE_I(strb[0]), .FB_STOP_I(strb[3]), .LOC_MOVE_I(strb[1]),
    .LOC_MODE_I(mode), .LOC_STOP_I(strb[4]), .LOC_WR_I(lwr), .LOC_INDEX_I(idx),
    .LOC_SUBINDEX_I(sub), .LOC_DATA_I(dat), .SIG_MANUAL_I(strb[2]), .SIG_STOP_I(strb[5]),
    .MOTION_FINISH_I(fin), .HOMED_I(homed), .AMP_ON_I(amp), .REMOTE_SELECT_ACK_O(ack),
    .PIN_FB_CFG_O(pfb), .PIN_FREE_IO_O(pfree), .PIN_FIXED_O(pfix), .START_O(st),
    .START_MODE_O(stm), .TARGET_O(tgt), .STOP_O(stp), .ACTIVE_MODE_O(am), .OWNER_O(own),
    .MOTION_DONE_O(dn), .REJECT_O(rej), .FB_ACK_VALID_O(akv), .FB_ACK_STATUS_O(aks),
    .FB_ACK_DATA_O(akd)
  );

  acms_core_model i_core
  (
    .clk_i(clk), .rst_i(srst), .start_i(st), .stop_i(stp), .delay_i(dly), .hold_i(hold),
    .finish_o(fin)
  );

  // --------------------------------------------------------------------------
  // drivers and checks; strobes rise and fall on falling edges
  // --------------------------------------------------------------------------
  task chk(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task fb_cmd(input logic [7:0] a, input logic [15:0] i, input logic [7:0] s,
              input logic [31:0] d);
    @(negedge clk);
    {fbv, acc, idx, sub, dat} = {1'b1, a, i, s, d};
    @(negedge clk);
    fbv = 1'b0;
  endtask

  // local write of the io assignment setting
  task io_set(input logic [31:0] d);
    @(negedge clk);
    {lwr, idx, sub, dat} = {1'b1, 16'h001D, 8'h1F, d};
    @(negedge clk);
    lwr = 1'b0;
    @(negedge clk);
  endtask

  task pulse(input int k, input logic [4:0] m);
    @(negedge clk);
    mode    = m;
    strb[k] = 1'b1;
    @(negedge clk);
    strb = 6'h00;
  endtask

  // done falls one cycle after START_O rises, so look only after two falling edges
  task wait_hi(input bit use_ack);
    repeat (2) @(negedge clk);
    for (int i = 0; i < 80 && !(use_ack ? ack === 1'b1 : dn === 1'b1); i++)
      @(negedge clk);
  endtask

  task tally_and_finish;
    if (n_fail == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // --------------------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------------------
  task t_reset;
    chk({pfb, pfree, pfix, dn, ack}, 5'b10010);
    fb_cmd(8'h03, 16'h0023, 8'h01, 32'hFFFF_FFFF);
    chk({akv, akd}, {1'b1, 32'h0000_0000});
    for (int v = 2; v >= 0; v--)
    begin
      io_set(v);
      chk({pfix, pfree, pfb}, 3'h1 << v);
    end
  endtask

  task t_walk;
    dly = 8'h06;
    fb_cmd(8'h04, 16'h0023, 8'h01, 32'h0000_0144);
    chk({st, stm, tgt}, {1'b1, 5'h03, 32'h0000_0144});
    chk({akv, aks[18:17], aks[5:0]}, {1'b1, 2'b10, 6'h23});
    @(negedge clk);
    chk(dn, 1'b0);
    chk(am, 5'h03);
    wait_hi(0);
    chk(dn, 1'b1);
    {homed, amp} = 2'b00;
    fb_cmd(8'h03, 16'h0023, 8'h01, 32'h0000_0000);
    chk(akd, 32'h0000_0144);
    chk({aks[18:17], aks[5:0]}, {2'b01, 6'h03});
    {homed, amp} = 2'b11;
  endtask

  // one channel owns a long move, the others are shut out but may stop it
  task t_excl;
    dly = 8'h14;
    pulse(1, 5'h04);
    chk({st, stm}, {1'b1, 5'h04});
    pulse(0, 5'h05);
    chk({rej, st, own}, {2'b10, 2'h1});
    pulse(5, 5'h00);
    chk(stp, 1'b1);
    wait_hi(0);
    pulse(0, 5'h06);
    chk({st, stm}, {1'b1, 5'h06});
    wait_hi(0);
    pulse(0, 5'h07);
    chk({rej, st}, 2'b10);
    pulse(2, 5'h00);
    chk({rej, st}, 2'b10);
    // the fieldbus locks the local tools out, then hands them back
    fb_cmd(8'h04, 16'h001D, 8'h1E, 32'h0000_0001);
    pulse(1, 5'h04);
    chk({rej, st}, 2'b10);
    fb_cmd(8'h04, 16'h001D, 8'h1E, 32'h0000_0000);
    pulse(1, 5'h04);
    chk({st, stm}, {1'b1, 5'h04});
    wait_hi(0);
  endtask

  task t_remote;
    io_set(32'h2);
    dly  = 8'h04;
    hold = 1'b1;
    pulse(2, 5'h00);
    chk({st, stm}, {1'b1, 5'h01});
    rsel = 1'b1;
    repeat (12) @(negedge clk);
    chk(ack, 1'b0);
    hold = 1'b0;
    wait_hi(1);
    chk(ack, 1'b1);
    pulse(1, 5'h03);
    chk({rej, st}, 2'b10);
    for (int i = 0; i < 5; i++)
    begin
      pulse(0, fbm[i]);
      chk({st, stm}, {1'b1, fbm[i]});
      wait_hi(0);
    end
    rsel = 1'b0;
    repeat (8) @(negedge clk);
    chk(ack, 1'b0);
    pulse(1, 5'h07);
    chk({st, stm}, {1'b1, 5'h07});
    wait_hi(0);
    io_set(32'h0);
  endtask

  initial
  begin
    repeat (16) @(negedge clk);
    srst = 1'b0;
    t_reset();
    t_walk();
    t_excl();
    t_remote();
    tally_and_finish();
  end

  // a hang is cut short well past the few hundred cycles the run needs
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_fail++;
      tally_and_finish();
    end
  end
endmodule // testbench

bind acms_top acms_chk i_chk
(
  .SYS_CLK_I, .SRST_I, .REMOTE_SELECT_I, .FB_CMD_VALID_I, .FB_ACCESS_I, .FB_SUBINDEX_I,
  .FB_INDEX_I, .FB_DATA_I, .FB_MODE_I, .FB_MOVE_I, .FB_STOP_I, .LOC_MOVE_I, .LOC_STOP_I,
  .LOC_WR_I, .SIG_MANUAL_I, .SIG_STOP_I, .MOTION_FINISH_I, .REMOTE_SELECT_ACK_O,
  .PIN_FB_CFG_O, .PIN_FREE_IO_O, .PIN_FIXED_O, .START_O, .START_MODE_O, .TARGET_O,
  .STOP_O, .MOTION_DONE_O, .REJECT_O, .FB_ACK_VALID_O
);

`default_nettype wire
